// >>> verilog/vtiming_pkg.sv
`default_nettype none
package vtiming_pkg;
  // axi4-lite geometry
  localparam int          ADDR_W       = 6;
  localparam int          DATA_W       = 32;
  localparam int          NUM_REGS     = 9;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  // register indices; byte address is index times four
  localparam logic [3:0]  REG_VTOTAL   = 4'h0;
  localparam logic [3:0]  REG_VDISP    = 4'h1;
  localparam logic [3:0]  REG_VSYNC    = 4'h2;
  localparam logic [3:0]  REG_VBLANK   = 4'h3;
  localparam logic [3:0]  REG_MAXSCAN  = 4'h4;
  localparam logic [3:0]  REG_SPLIT    = 4'h5;
  localparam logic [3:0]  REG_SADDR_HI = 4'h6;
  localparam logic [3:0]  REG_SADDR_LO = 4'h7;
  localparam logic [3:0]  REG_OVERFLOW = 4'h8;
  localparam logic [3:0]  REG_STATUS   = 4'h9;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  // overflow register bit positions
  localparam int          OVF_VT8      = 0;
  localparam int          OVF_VDE8     = 1;
  localparam int          OVF_VS8      = 2;
  localparam int          OVF_VB8      = 3;
  localparam int          OVF_LC8      = 4;
  localparam int          OVF_VT9      = 5;
  localparam int          OVF_VDE9     = 6;
  localparam int          OVF_VS9      = 7;
  // max-scan-line register bit positions
  localparam int          MSL_VB9      = 5;
  localparam int          MSL_LC9      = 6;
  // status register field positions
  localparam int          ST_VSYNC     = 10;
  localparam int          ST_VBLANK    = 11;
  localparam int          ST_DISP      = 12;
  // timing counts
  localparam int          LINE_CYCLES  = 800;
  localparam int          VSYNC_LINES  = 2;
  localparam logic [15:0] FETCH_STRIDE = 16'h0050;
endpackage
`default_nettype wire

// >>> verilog/vtiming.sv
// Overview of operation
// (R1) split line = max-scan bit 6, overflow bit 4, split low byte.
// (R2) at split line the display address counter reloads to zero.
// (R3) above split fetch from start address; below it from byte zero.
// (R4) software puts split line past last active line when unused.
// (R5) blank start = max-scan bit 5, overflow bit 3, blank low byte.
// (R6) vertical blanking begins on the line equal to blank start.
// (R7) sync start = overflow bit 7, overflow bit 2, sync low byte.
// (R8) vertical sync begins on the line equal to sync start.
// (R9) display end = overflow bit 6, overflow bit 1, display-end low byte.
// (R10) display end is the last active line; active display stops after it.
// (R11) vertical total = overflow bit 5, overflow bit 0, total low byte.
// (R12) software programs vertical total as lines per frame minus two.
// (R13) line counter starts at zero, counts per line, wraps after total; the code wraps after total plus one.
`timescale 1ns/10ps
`default_nettype none
module vtiming #(
  parameter int          LINE_CYCLES  = vtiming_pkg::LINE_CYCLES,
  parameter int          VSYNC_LINES  = vtiming_pkg::VSYNC_LINES,
  parameter logic [15:0] FETCH_STRIDE = vtiming_pkg::FETCH_STRIDE
) (
  // clock and reset
  input  wire logic                            CORE_CLK,
  input  wire logic                            RST_N,
  // axi4-lite write
  input  wire logic [vtiming_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
  input  wire logic                            S_AXI_AWVALID,
  output logic                                 S_AXI_AWREADY,
  input  wire logic [vtiming_pkg::DATA_W-1:0]  S_AXI_WDATA,
  input  wire logic [3:0]                      S_AXI_WSTRB,
  input  wire logic                            S_AXI_WVALID,
  output logic                                 S_AXI_WREADY,
  output logic [1:0]                           S_AXI_BRESP,
  output logic                                 S_AXI_BVALID,
  input  wire logic                            S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [vtiming_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
  input  wire logic                            S_AXI_ARVALID,
  output logic                                 S_AXI_ARREADY,
  output logic [vtiming_pkg::DATA_W-1:0]       S_AXI_RDATA,
  output logic [1:0]                           S_AXI_RRESP,
  output logic                                 S_AXI_RVALID,
  input  wire logic                            S_AXI_RREADY,
  // vertical timing
  output logic                                 VSYNC,
  output logic                                 VBLANK,
  output logic                                 VDISP_EN,
  output logic [9:0]                           SCAN_LINE,
  output logic [15:0]                          FETCH_ADDR,
  output logic                                 ADDR_RELOAD
);
  import vtiming_pkg::*;

  localparam logic [15:0] LINE_LAST  = 16'(LINE_CYCLES - 1);
  localparam logic [3:0]  SYNC_LINES = 4'(VSYNC_LINES);

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic                     aw_held;
    logic [ADDR_W-1:0]        awaddr;
    logic                     w_held;
    logic [7:0]               wdata;
    logic                     wlane0;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [DATA_W-1:0]        rdata;
    logic [15:0]              div;
    logic [9:0]               line;
    logic                     vsync;
    logic [3:0]               sync_cnt;
    logic                     vblank;
    logic                     disp_en;
    logic [15:0]              addr;
    logic                     reload;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   rst_meta_q;
  logic   rst_n;

  // reset released through two flops so every state flop leaves reset together
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // assembled 10-bit vertical parameters
  logic [9:0]  split_val;
  logic [9:0]  vblank_val;
  logic [9:0]  vsync_val;
  logic [9:0]  vdisp_val;
  logic [9:0]  vtotal_val;
  logic [10:0] wrap_line;
  logic        wrap;
  logic        tick;
  logic [9:0]  nxt_line;

  assign split_val  = {s_q.regs[REG_MAXSCAN][MSL_LC9], s_q.regs[REG_OVERFLOW][OVF_LC8],
                       s_q.regs[REG_SPLIT]}; // R1
  assign vblank_val = {s_q.regs[REG_MAXSCAN][MSL_VB9], s_q.regs[REG_OVERFLOW][OVF_VB8],
                       s_q.regs[REG_VBLANK]}; // R5
  assign vsync_val  = {s_q.regs[REG_OVERFLOW][OVF_VS9], s_q.regs[REG_OVERFLOW][OVF_VS8],
                       s_q.regs[REG_VSYNC]}; // R7
  assign vdisp_val  = {s_q.regs[REG_OVERFLOW][OVF_VDE9], s_q.regs[REG_OVERFLOW][OVF_VDE8],
                       s_q.regs[REG_VDISP]}; // R9
  assign vtotal_val = {s_q.regs[REG_OVERFLOW][OVF_VT9], s_q.regs[REG_OVERFLOW][OVF_VT8],
                       s_q.regs[REG_VTOTAL]}; // R11
  // total counts lines minus two, so the last line is total plus one
  assign wrap_line  = {1'b0, vtotal_val} + 11'h001; // R13
  // >= so a shrunk total mid-frame still wraps instead of running to 1023
  assign wrap       = {1'b0, s_q.line} >= wrap_line;
  assign tick       = s_q.div == LINE_LAST;
  assign nxt_line   = wrap ? 10'h000 : s_q.line + 10'h001; // R13

  assign S_AXI_AWREADY = !s_q.aw_held && !s_q.bvalid;
  assign S_AXI_WREADY  = !s_q.w_held && !s_q.bvalid;
  assign S_AXI_ARREADY = !s_q.rvalid;

  logic [3:0] ridx;
  logic [3:0] widx;
  logic       whit;
  assign ridx = S_AXI_ARADDR[ADDR_W-1:2];
  assign widx = s_q.awaddr[ADDR_W-1:2];
  assign whit = (s_q.awaddr[1:0] == 2'b00) && (widx < 4'(NUM_REGS));

  always_comb begin
    s_d        = s_q;
    s_d.reload = 1'b0;
    // register bus, write path: address and data may arrive in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_d.w_held = 1'b1;
      s_d.wdata  = S_AXI_WDATA[7:0];
      s_d.wlane0 = S_AXI_WSTRB[0];
    end
    if (s_q.aw_held && s_q.w_held) begin
      if (whit && s_q.wlane0) begin
        s_d.regs[widx] = s_q.wdata;
      end
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = whit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    // read path: one-cycle answer, status is read-only
    if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = '0;
      if (S_AXI_ARADDR[1:0] != 2'b00) begin
        s_d.rresp = RESP_SLVERR;
      end else if (ridx < 4'(NUM_REGS)) begin
        s_d.rdata[7:0] = s_q.regs[ridx];
      end else if (ridx == REG_STATUS) begin
        s_d.rdata[9:0]       = s_q.line;
        s_d.rdata[ST_VSYNC]  = s_q.vsync;
        s_d.rdata[ST_VBLANK] = s_q.vblank;
        s_d.rdata[ST_DISP]   = s_q.disp_en;
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end
    // line-rate divider; pixel timing lives outside this block
    s_d.div = tick ? 16'h0000 : s_q.div + 16'h0001;
    if (tick) begin
      s_d.line = nxt_line; // R13
      if (nxt_line == split_val) begin
        // split wins over frame start so a split at line zero shows byte zero
        s_d.addr   = 16'h0000; // R2
        s_d.reload = 1'b1; // R2
      end else if (nxt_line == 10'h000) begin
        s_d.addr = {s_q.regs[REG_SADDR_HI], s_q.regs[REG_SADDR_LO]}; // R3
      end else begin
        s_d.addr = s_q.addr + FETCH_STRIDE; // R3
      end
      if (nxt_line == 10'h000) begin
        s_d.disp_en = 1'b1;
        s_d.vblank  = 1'b0;
      end else if (s_q.line == vdisp_val) begin
        s_d.disp_en = 1'b0; // R10
      end
      if (nxt_line == vblank_val) begin
        s_d.vblank = 1'b1; // R6
      end
      if (nxt_line == vsync_val) begin
        s_d.vsync    = 1'b1; // R8
        s_d.sync_cnt = SYNC_LINES;
      end else if (s_q.sync_cnt > 4'h1) begin
        s_d.sync_cnt = s_q.sync_cnt - 4'h1;
      end else begin
        s_d.vsync    = 1'b0;
        s_d.sync_cnt = 4'h0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.regs    <= {NUM_REGS{REG_RESET}};
      s_q.disp_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP  = s_q.bresp;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RRESP  = s_q.rresp;
  assign S_AXI_RDATA  = s_q.rdata;
  assign VSYNC        = s_q.vsync;
  assign VBLANK       = s_q.vblank;
  assign VDISP_EN     = s_q.disp_en;
  assign SCAN_LINE    = s_q.line;
  assign FETCH_ADDR   = s_q.addr;
  assign ADDR_RELOAD  = s_q.reload;

  property p_split;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && nxt_line == {s_q.regs[REG_MAXSCAN][6], s_q.regs[REG_OVERFLOW][4], s_q.regs[REG_SPLIT]}
      |=> FETCH_ADDR == 16'h0000 && ADDR_RELOAD ##1 !ADDR_RELOAD;
  endproperty
  a_split: assert property (p_split) else $error("split line did not reload address to zero"); // R2
  property p_start;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && wrap && split_val != 10'h000
      |=> SCAN_LINE == 10'h000 && FETCH_ADDR == {$past(s_q.regs[REG_SADDR_HI]), $past(s_q.regs[REG_SADDR_LO])};
  endproperty
  a_start: assert property (p_start) else $error("frame did not start at start address"); // R3
  property p_vblank;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && nxt_line == {s_q.regs[REG_MAXSCAN][5], s_q.regs[REG_OVERFLOW][3], s_q.regs[REG_VBLANK]}
      |=> VBLANK && SCAN_LINE == $past(nxt_line);
  endproperty
  a_vblank: assert property (p_vblank) else $error("blanking did not begin on its line"); // R6
  property p_vsync;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && nxt_line == {s_q.regs[REG_OVERFLOW][7], s_q.regs[REG_OVERFLOW][2], s_q.regs[REG_VSYNC]}
      |=> VSYNC && SCAN_LINE == $past(nxt_line);
  endproperty
  a_vsync: assert property (p_vsync) else $error("sync did not begin on its line"); // R8
  property p_disp;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && !wrap && s_q.line == {s_q.regs[REG_OVERFLOW][6], s_q.regs[REG_OVERFLOW][1], s_q.regs[REG_VDISP]}
      |=> !VDISP_EN;
  endproperty
  a_disp: assert property (p_disp) else $error("display stayed on past last active line"); // R10
  property p_wrap;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && {1'b0, s_q.line} == {1'b0, s_q.regs[REG_OVERFLOW][5], s_q.regs[REG_OVERFLOW][0],
                                 s_q.regs[REG_VTOTAL]} + 11'h001
      |=> SCAN_LINE == 10'h000 && VDISP_EN && VBLANK == ($past(vblank_val) == 10'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("line counter did not wrap after total"); // R13
  property p_inc;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && !wrap |=> SCAN_LINE == $past(SCAN_LINE) + 10'h001 ##1 SCAN_LINE == $past(SCAN_LINE);
  endproperty
  a_inc: assert property (p_inc) else $error("line counter did not step once per line"); // R13
  property p_reload;
    @(posedge CORE_CLK) disable iff (!rst_n)
    ADDR_RELOAD |-> FETCH_ADDR == 16'h0000 && SCAN_LINE == $past(split_val);
  endproperty
  a_reload: assert property (p_reload) else $error("address reload off the split line"); // R2
  property p_step;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && !wrap && nxt_line != split_val && nxt_line != 10'h000
      |=> FETCH_ADDR == $past(FETCH_ADDR) + FETCH_STRIDE;
  endproperty
  a_step: assert property (p_step) else $error("display address did not step by one line"); // R3
  property p_bkeep;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && VBLANK && !wrap && nxt_line != 10'h000 |=> VBLANK;
  endproperty
  a_bkeep: assert property (p_bkeep) else $error("blanking ended before frame end"); // R6
  property p_dkeep;
    @(posedge CORE_CLK) disable iff (!rst_n)
    tick && !VDISP_EN && !wrap && nxt_line != 10'h000 |=> !VDISP_EN;
  endproperty
  a_dkeep: assert property (p_dkeep) else $error("display came back on before frame end"); // R10
  property p_bhold;
    @(posedge CORE_CLK) disable iff (!rst_n)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped before taken");
endmodule
`default_nettype wire

// >>> testbench/display_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module display_monitor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // timing seen at the screen
  input  wire logic        vdisp_en,
  input  wire logic [9:0]  scan_line,
  // line events
  output logic             line_stb,
  output logic [10:0]      frame_lines
);
  logic [9:0]  prev_q;
  logic        de_q;
  logic [10:0] cnt_q;
  // a new line shows only as a change of the line number
  assign line_stb = (scan_line != prev_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q      <= '0;
      de_q        <= 1'b1;
      cnt_q       <= '0;
      frame_lines <= '0;
    end else begin
      prev_q <= scan_line;
      de_q   <= vdisp_en;
      // frame measured from one display start to the next
      if (vdisp_en && !de_q) begin
        frame_lines <= cnt_q;
        cnt_q       <= 11'h001;
      end else if (line_stb) begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_vtiming.sv
`timescale 1ns/10ps
`default_nettype none
module tb_vtiming;
  import vtiming_pkg::*;
  localparam int LC = 8;
  logic        clk;
  logic        rst_n = 1'b0;
  logic [5:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, vsync, vblank, vdisp_en, addr_reload, line_stb;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [9:0]  scan_line;
  wire logic [15:0] fetch_addr;
  wire logic [10:0] frame_lines;
  int          error_cnt = 0, n_tests = 0, cyc = 0;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [31:0] seed = 32'h13bb6d51;
  logic [9:0]  e_vt, e_vd, e_vs, e_vb, e_sp, e_ln;
  logic [15:0] e_sa, e_addr;
  logic        chk_on = 1'b0;
  vtiming #(.LINE_CYCLES(LC)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .VSYNC(vsync), .VBLANK(vblank), .VDISP_EN(vdisp_en),
    .SCAN_LINE(scan_line), .FETCH_ADDR(fetch_addr), .ADDR_RELOAD(addr_reload));
  display_monitor mon (.clk(clk), .rst_n(rst_n), .vdisp_en(vdisp_en), .scan_line(scan_line),
    .line_stb(line_stb), .frame_lines(frame_lines));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_h, w_h, b_h;
    exp_b.push_back(er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // ready sampled half a cycle early; inputs are steady until the edge
    do begin
      @(negedge clk);
      aw_h = awvalid & awready;
      w_h  = wvalid & wready;
      b_h  = bvalid & bready;
      @(posedge clk);
      if (aw_h) awvalid <= 1'b0;
      if (w_h) wvalid <= 1'b0;
      if (b_h) bready <= 1'b0;
    end while (!b_h);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ar_h, r_h;
    exp_r.push_back({er, d});
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      ar_h = arvalid & arready;
      r_h  = rvalid & rready;
      @(posedge clk);
      if (ar_h) arvalid <= 1'b0;
      if (r_h) rready <= 1'b0;
    end while (!r_h);
  endtask
  task automatic cfg(input logic [9:0] vt, vd, vs, vb, sp);
    logic [7:0] ovf;
    int         i;
    ovf  = {vs[9], vd[9], vt[9], sp[8], vb[8], vs[8], vd[8], vt[8]};
    e_vt = vt;
    e_vd = vd;
    e_vs = vs;
    e_vb = vb;
    e_sp = sp;
    e_sa = 16'(rnd());
    wr({REG_VTOTAL, 2'b00}, {24'h0, vt[7:0]}, 4'hf, RESP_OKAY);
    wr({REG_VDISP, 2'b00}, {24'h0, vd[7:0]}, 4'hf, RESP_OKAY);
    wr({REG_VSYNC, 2'b00}, {24'h0, vs[7:0]}, 4'hf, RESP_OKAY);
    wr({REG_VBLANK, 2'b00}, {24'h0, vb[7:0]}, 4'hf, RESP_OKAY);
    wr({REG_SPLIT, 2'b00}, {24'h0, sp[7:0]}, 4'hf, RESP_OKAY);
    wr({REG_MAXSCAN, 2'b00}, {24'h0, 1'b0, sp[9], vb[9], 5'h00}, 4'hf, RESP_OKAY);
    wr({REG_OVERFLOW, 2'b00}, {24'h0, ovf}, 4'hf, RESP_OKAY);
    wr({REG_SADDR_HI, 2'b00}, {24'h0, e_sa[15:8]}, 4'hf, RESP_OKAY);
    wr({REG_SADDR_LO, 2'b00}, {24'h0, e_sa[7:0]}, 4'hf, RESP_OKAY);
    rd({REG_OVERFLOW, 2'b00}, {24'h0, ovf}, RESP_OKAY);
    // start checking from the last line of a frame
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (i < 20000 && !(line_stb && scan_line == vt + 10'h001));
    check("line wait", {31'h0, i < 20000}, 32'h1);
    // last line of the frame: blanking on, display off, sync over in every set used here
    rd({REG_STATUS, 2'b00}, {19'h0, 1'b0, 1'b1, 1'b0, vt + 10'h001}, RESP_OKAY);
    @(posedge clk);
    e_ln   = vt + 10'h001;
    chk_on = 1'b1;
    repeat ((vt + 3) * LC + 4) @(posedge clk);
    chk_on = 1'b0;
    check("frame_lines", {21'h0, frame_lines}, {22'h0, vt} + 32'h2);
  endtask
  always @(negedge clk) begin
    logic [33:0] e;
    if (bvalid && bready) check("bresp", {30'h0, bresp}, {30'h0, exp_b.pop_front()});
    if (rvalid && rready) begin
      e = exp_r.pop_front();
      check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
      if (e[33:32] == RESP_OKAY) check("rdata", rdata, e[31:0]);
    end
    if (chk_on && line_stb) begin
      e_ln   = (e_ln == e_vt + 10'h001) ? 10'h000 : e_ln + 10'h001;
      e_addr = (e_ln == e_sp) ? 16'h0000 : (e_ln == 10'h000) ? e_sa : e_addr + FETCH_STRIDE;
      check("scan_line", {22'h0, scan_line}, {22'h0, e_ln});
      check("fetch_addr", {16'h0, fetch_addr}, {16'h0, e_addr});
      check("addr_reload", {31'h0, addr_reload}, {31'h0, e_ln == e_sp});
      check("vdisp_en", {31'h0, vdisp_en}, {31'h0, e_ln <= e_vd});
      check("vblank", {31'h0, vblank}, {31'h0, e_ln >= e_vb});
      check("vsync", {31'h0, vsync}, {31'h0, e_ln >= e_vs && e_ln < e_vs + VSYNC_LINES});
    end
  end
  // ceiling well above three configured frames and their waits
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int r = 0; r < NUM_REGS; r++) rd(6'(r * 4), {24'h0, REG_RESET}, RESP_OKAY);
    wr(6'h28, 32'h5a, 4'hf, RESP_SLVERR);
    rd(6'h28, 32'h0, RESP_SLVERR);
    wr(6'h02, 32'h5a, 4'hf, RESP_SLVERR);
    wr({REG_STATUS, 2'b00}, 32'h5a, 4'hf, RESP_SLVERR);
    // strobe off: accepted but nothing stored
    wr({REG_SPLIT, 2'b00}, 32'ha5, 4'h0, RESP_OKAY);
    rd({REG_SPLIT, 2'b00}, {24'h0, REG_RESET}, RESP_OKAY);
    cfg(10'h105, 10'h101, 10'h104, 10'h102, 10'h100);
    cfg(10'h301, 10'h2f0, 10'h2fa, 10'h2f5, 10'h200);
    cfg(10'h105, 10'h0f0, 10'h0f8, 10'h0f4, 10'h3ff);
    stop_test();
  end
endmodule
`default_nettype wire
